// *** shared/exc_vec_pkg.sv ***
// Constants for the exception vector address generator.
`default_nettype none
package exc_vec_pkg;
  localparam int          ADDR_W          = 32;        // Fetch address width.
  localparam int          CODE_W          = 5;         // Exception index width.
  localparam int          PIN_N           = 8;         // Fixed-priority request pins.
  localparam int          LVL_W           = 3;         // Width of an assigned level.
  localparam int          RANK_W          = 4;         // Width of a priority rank.
  localparam logic [31:0] BASE_LOW        = 32'h0000_0000; // Base with high select clear.
  localparam logic [31:0] BASE_HIGH       = 32'hfff0_0000; // Base with high select set.
  localparam logic [31:0] RELOC_ONE_BIT   = 32'h0000_8000; // Extra base, one-bit select.
  localparam logic [31:0] RELOC_CODE_00   = 32'h0000_0000; // Two-bit field code 00.
  localparam logic [31:0] RELOC_CODE_01   = 32'h0001_0000; // Two-bit field code 01.
  localparam logic [31:0] RELOC_CODE_10   = 32'h0008_0000; // Two-bit field code 10.
  localparam logic [31:0] RELOC_CODE_11   = 32'h003f_e000; // Two-bit field code 11.
  localparam int          NORM_SHIFT      = 8;         // Normal spacing 0x100 bytes.
  localparam int          RELOC_SHIFT     = 3;         // Relocated spacing 8 bytes.
  localparam logic [4:0]  CODE_RESET      = 5'h01;     // Reset or non-maskable, 0x100.
  localparam logic [4:0]  CODE_MCHECK     = 5'h02;     // Machine check, 0x200.
  localparam logic [4:0]  CODE_RSVD_3     = 5'h03;     // Reserved, 0x300.
  localparam logic [4:0]  CODE_RSVD_4     = 5'h04;     // Reserved, 0x400.
  localparam logic [4:0]  CODE_EXT_INT    = 5'h05;     // Shared external interrupt, 0x500.
endpackage
`default_nettype wire

// *** hw/exception_vector_address_gen.sv ***
// Exception vector address generator with interrupt source arbitration.
`timescale 1ns/1ps
`default_nettype none
module exception_vector_address_gen
  import exc_vec_pkg::*;
#(
  parameter int          SRC_N     = 8,      // Number of level-assigned internal sources.
  parameter bit          TWO_BIT   = 1'b0,   // Selects the two-bit relocate field variant.
  parameter int          ISB_SHIFT = 22      // Weight of one internal space base step.
) (
  input  wire logic                    core_clk,                 // Core clock.
  input  wire logic                    rst_b,                    // Async reset, active low.
  input  wire logic                    exc_req,                  // Core exception request.
  input  wire logic [CODE_W-1:0]       exc_code,                 // Exception index.
  input  wire logic [ADDR_W-1:0]       machine_state_reg,        // Live machine state.
  input  wire logic                    vector_high_select,       // Base select bit.
  input  wire logic                    ext_int_enable,           // Core accepts interrupts.
  input  wire logic                    table_relocate_enable,    // Relocation enable.
  input  wire logic                    relocate_offset_select,   // One-bit extra base.
  input  wire logic                    relocate_offset_select_hi,// Two-bit field, upper.
  input  wire logic                    relocate_offset_select_lo,// Two-bit field, lower.
  input  wire logic [2:0]              internal_space_base,      // Internal space base.
  input  wire logic [PIN_N-1:0]        irq_pin_req,              // Request pins.
  input  wire logic [SRC_N-1:0]        src_req,                  // Internal requests.
  input  wire logic [SRC_N*LVL_W-1:0]  src_level,                // Assigned levels.
  output logic                         fetch_redirect_r,         // Redirect, high the cycle after each take.
  output logic [ADDR_W-1:0]            vector_addr_r,            // Vector to fetch from.
  output logic [CODE_W-1:0]            taken_code_r,             // Exception taken.
  output logic                         vector_reserved_r,        // Taken code is reserved.
  output logic [ADDR_W-1:0]            saved_state_r,            // State saved at entry.
  output logic                         int_pending_r,            // An interrupt is requested.
  output logic [RANK_W-1:0]            int_rank_r                // Winning priority rank.
);

  logic                 reloc_on;      // Relocation really in force.
  logic [ADDR_W-1:0]    isb_off;       // Internal space base offset.
  logic [ADDR_W-1:0]    extra_base;    // Extra relocated base.
  logic [ADDR_W-1:0]    base_sel;      // Selected exception base.
  logic [ADDR_W-1:0]    offset_sel;    // Selected vector offset.
  logic                 take;          // An exception is taken this cycle.
  logic [CODE_W-1:0]    code_sel;      // Code of the exception taken.
  logic                 int_any;       // Some request is active.
  logic [RANK_W-1:0]    rank_best;     // Best rank among requests.

  // Relocation needs the high select bit; otherwise enable is ignored.
  assign reloc_on = vector_high_select & table_relocate_enable;
  assign isb_off  = ADDR_W'(internal_space_base) << ISB_SHIFT;

  // Extra base from either the one-bit select or the two-bit field.
  always_comb begin
    extra_base = RELOC_CODE_00;
    if (TWO_BIT) begin
      // Four fixed table locations.
      unique case ({relocate_offset_select_hi, relocate_offset_select_lo})
        2'b00: extra_base = RELOC_CODE_00;
        2'b01: extra_base = RELOC_CODE_01;
        2'b10: extra_base = RELOC_CODE_10;
        2'b11: extra_base = RELOC_CODE_11;
      endcase
    end else if (relocate_offset_select) begin
      // Single bit adds the fixed extra base.
      extra_base = RELOC_ONE_BIT;
    end
  end

  // Base selection and offset spacing.
  always_comb begin
    if (reloc_on) begin
      // Relocated table moves with internal space.
      base_sel   = extra_base + isb_off;
      offset_sel = ADDR_W'(code_sel) << RELOC_SHIFT;
    end else begin
      // Plain base chosen by the high select bit.
      base_sel   = vector_high_select ? BASE_HIGH : BASE_LOW;
      offset_sel = ADDR_W'(code_sel) << NORM_SHIFT;
    end
  end

  // Fixed rank for pins and levels, pin i at 2i and level j at 2j+1.
  always_comb begin
    int_any   = 1'b0;
    rank_best = '1;
    for (int i = PIN_N - 1; i >= 0; i--) begin
      // Lower pin index wins among pins.
      if (irq_pin_req[i] && RANK_W'(2 * i) <= rank_best) begin
        rank_best = RANK_W'(2 * i);
        int_any   = 1'b1;
      end
    end
    for (int j = 0; j < SRC_N; j++) begin
      // Assigned level sets the rank of an internal source.
      if (src_req[j] && RANK_W'(2 * src_level[j*LVL_W +: LVL_W] + 1) < rank_best) begin
        rank_best = RANK_W'(2 * src_level[j*LVL_W +: LVL_W] + 1);
        int_any   = 1'b1;
      end else if (src_req[j]) begin
        int_any   = 1'b1;
      end
    end
  end

  // A core exception goes first; otherwise an interrupt takes 0x500.
  assign take     = exc_req | (int_any & ext_int_enable);
  assign code_sel = exc_req ? exc_code : CODE_EXT_INT;

  // Redirect pulse, vector and taken code.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_redirect_r  <= 1'b0;
      vector_addr_r     <= BASE_LOW;
      taken_code_r      <= '0;
      vector_reserved_r <= 1'b0;
    end else begin
      fetch_redirect_r <= take;
      if (take) begin
        // Sum of base and offset.
        vector_addr_r     <= base_sel + offset_sel;
        taken_code_r      <= code_sel;
        vector_reserved_r <= (code_sel == CODE_RSVD_3) || (code_sel == CODE_RSVD_4);
      end
    end
  end

  // Machine state captured as the exception is taken.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      saved_state_r <= '0;
    end else if (take) begin
      saved_state_r <= machine_state_reg;
    end
  end

  // Interrupt arbitration result.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      int_pending_r <= 1'b0;
      int_rank_r    <= '1;
    end else begin
      int_pending_r <= int_any;
      int_rank_r    <= rank_best;
    end
  end

  // Checks. Each property looks one cycle after the edge that sampled its
  // condition, where the registered outputs first show the result.
  // Taking an exception, from the core or from the shared interrupt.
  sequence s_taken;
    take;
  endsequence

  // Nothing is taken this cycle.
  sequence s_idle;
    !take;
  endsequence

  // The core itself raises an exception.
  sequence s_core_exc;
    exc_req;
  endsequence

  AST_REDIRECT: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_taken |=> fetch_redirect_r && saved_state_r == $past(machine_state_reg))
    else $error("redirect or state save missing");
  AST_LOW_BASE: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && !vector_high_select |=> vector_addr_r == {$past(exc_code), 8'h00})
    else $error("low base vector wrong");
  AST_HIGH_BASE: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && vector_high_select && !table_relocate_enable
    |=> vector_addr_r == (BASE_HIGH | {$past(exc_code), 8'h00}))
    else $error("high base vector wrong");
  AST_RESERVED: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && (exc_code == CODE_RSVD_3 || exc_code == CODE_RSVD_4) |=> vector_reserved_r)
    else $error("reserved code not flagged");
  AST_EXT_INT: assert property (@(posedge core_clk) disable iff (!rst_b)
    !exc_req && ext_int_enable && |irq_pin_req |=> taken_code_r == CODE_EXT_INT)
    else $error("interrupt not sent to shared vector");
  AST_STEP8: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && reloc_on && !relocate_offset_select && !TWO_BIT && internal_space_base == 3'h0
    |=> vector_addr_r == 32'({$past(exc_code), 3'h0}))
    else $error("relocated spacing wrong");
  AST_NEED_HIGH: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && !vector_high_select && table_relocate_enable |=> vector_addr_r[7:0] == 8'h00)
    else $error("relocation active without high select");
  AST_EXTRA_8000: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && reloc_on && relocate_offset_select && !TWO_BIT && internal_space_base == 3'h0
    |=> vector_addr_r == RELOC_ONE_BIT + 32'({$past(exc_code), 3'h0}))
    else $error("extra relocated base missing");
  // Every relocated table plus offset stays below one base step, so the upper bits are the base.
  AST_ISB: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && reloc_on |=> vector_addr_r[ADDR_W-1:ISB_SHIFT] == $past(internal_space_base))
    else $error("table does not follow internal space");
  AST_PIN0: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_pin_req[0] |=> int_pending_r && int_rank_r == '0)
    else $error("pin zero not highest priority");
  // A cycle without a take drops the redirect and leaves the vector alone.
  AST_IDLE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_idle |=> !fetch_redirect_r && $stable(vector_addr_r) && $stable(taken_code_r))
    else $error("outputs moved without an exception");
  // A core exception wins over any pending interrupt and keeps its own code.
  AST_EXC_FIRST: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_core_exc |=> taken_code_r == $past(exc_code))
    else $error("core exception code not taken");
  // Masked interrupts never redirect fetch.
  AST_MASKED: assert property (@(posedge core_clk) disable iff (!rst_b)
    !exc_req && !ext_int_enable |=> !fetch_redirect_r)
    else $error("masked interrupt redirected fetch");
  // Two-bit variant, field 11, moved by the internal space offset.
  AST_FIELD_11: assert property (@(posedge core_clk) disable iff (!rst_b)
    exc_req && reloc_on && TWO_BIT && relocate_offset_select_hi && relocate_offset_select_lo
    |=> vector_addr_r == RELOC_CODE_11 + (32'($past(internal_space_base)) << ISB_SHIFT)
        + 32'({$past(exc_code), 3'h0}))
    else $error("two-bit field 11 base wrong");
endmodule
`default_nettype wire

// *** sim/core_seq_model.sv ***
// Model of the core sequencer that raises exceptions toward the generator.
`timescale 1ns/1ps
`default_nettype none
module core_seq_model
  import exc_vec_pkg::*;
(
  input  wire logic              core_clk,
  output logic                   exc_req,
  output logic [CODE_W-1:0]      exc_code,
  output logic [ADDR_W-1:0]      machine_state_reg
);
  // Quiet until the bench asks for an exception.
  initial begin
    exc_req = 1'b0;
    exc_code = 5'h00;
    machine_state_reg = 32'h0000_0000;
  end
  // One request held across one rising edge, then the live state moves on.
  task automatic raise(input logic [CODE_W-1:0] c, input logic [ADDR_W-1:0] st);
    @(negedge core_clk);
    exc_req = 1'b1;
    exc_code = c;
    machine_state_reg = st;
    @(negedge core_clk);
    exc_req = 1'b0;
    machine_state_reg = ~st;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_exception_vector_address_gen.sv ***
// Testbench for the exception vector address generator.
`timescale 1ns/1ps
`default_nettype none
module tb_exception_vector_address_gen
  import exc_vec_pkg::*;
;
  logic core_clk, rst_b, exc_req, vector_high_select, ext_int_enable;
  logic table_relocate_enable, relocate_offset_select;
  logic relocate_offset_select_hi, relocate_offset_select_lo;
  logic [4:0] exc_code;
  logic [31:0] machine_state_reg, vector_addr_r, saved_state_r, vaddr_two;
  logic [2:0] internal_space_base;
  logic [7:0] irq_pin_req, src_req;
  logic [23:0] src_level;
  logic fetch_redirect_r, vector_reserved_r, int_pending_r;
  logic [4:0] taken_code_r;
  logic [3:0] int_rank_r;
  int n_errors = 0;
  int check_count = 0;
  core_seq_model core_seq_model_inst (.core_clk, .exc_req, .exc_code, .machine_state_reg);
  exception_vector_address_gen exception_vector_address_gen_inst (.core_clk, .rst_b,
    .exc_req, .exc_code, .machine_state_reg, .vector_high_select, .ext_int_enable,
    .table_relocate_enable, .relocate_offset_select, .relocate_offset_select_hi,
    .relocate_offset_select_lo, .internal_space_base, .irq_pin_req, .src_req, .src_level,
    .fetch_redirect_r, .vector_addr_r, .taken_code_r, .vector_reserved_r, .saved_state_r,
    .int_pending_r, .int_rank_r);
  // Two-bit relocate field variant, fed the same inputs.
  exception_vector_address_gen #(.TWO_BIT(1'b1)) exception_vector_address_gen_inst2 (
    .core_clk, .rst_b, .exc_req, .exc_code, .machine_state_reg, .vector_high_select,
    .ext_int_enable, .table_relocate_enable, .relocate_offset_select,
    .relocate_offset_select_hi, .relocate_offset_select_lo, .internal_space_base,
    .irq_pin_req, .src_req, .src_level, .fetch_redirect_r(), .vector_addr_r(vaddr_two),
    .taken_code_r(), .vector_reserved_r(), .saved_state_r(), .int_pending_r(),
    .int_rank_r());
  // Free-running core clock, 10 ns period.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Compares one result and counts it.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Expected vector for the present control inputs.
  function automatic logic [31:0] exp_vec(input logic [4:0] c, input logic two);
    logic [31:0] time_base_lower [4] = '{32'h0, 32'h0001_0000, 32'h0008_0000, 32'h003f_e000};
    logic [31:0] extra;
    if (!vector_high_select) return {19'h0, c, 8'h00};
    if (!table_relocate_enable) return 32'hfff0_0000 + {19'h0, c, 8'h00};
    extra = two ? time_base_lower[{relocate_offset_select_hi, relocate_offset_select_lo}]
                : (relocate_offset_select ? 32'h0000_8000 : 32'h0);
    return extra + ({29'h0, internal_space_base} << 22) + {24'h0, c, 3'h0};
  endfunction
  // Stops the run and prints the verdict.
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog against a hang.
  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    {rst_b, vector_high_select, ext_int_enable, table_relocate_enable} = 4'h0;
    {relocate_offset_select, relocate_offset_select_hi, relocate_offset_select_lo} = 3'h0;
    {internal_space_base, irq_pin_req, src_req, src_level} = '0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    for (int i = 0; i < 10; i++) begin
      vector_high_select = i[0];
      core_seq_model_inst.raise(5'(i / 2 + 1), 32'ha5a5_0000 + i);
      chk("redirect", 32'h1, {31'h0, fetch_redirect_r});
      chk("saved", 32'ha5a5_0000 + i, saved_state_r);
      chk("code", i / 2 + 1, {27'h0, taken_code_r});
      chk("vector", exp_vec(5'(i / 2 + 1), 1'b0), vector_addr_r);
      chk("reserved", (i / 2 == 2 || i / 2 == 3), {31'h0, vector_reserved_r});
    end
    $display("test normal vectors done");
    table_relocate_enable = 1'b1;
    for (int k = 0; k < 9; k++) begin
      logic [4:0] kc;
      kc = k[0] ? 5'h05 : 5'h02;
      vector_high_select = (k < 8);
      relocate_offset_select = k[0];
      {relocate_offset_select_hi, relocate_offset_select_lo} = k[1:0];
      // Base steps every second pass, so the extra base is also seen on a zero base.
      internal_space_base = k[3:1];
      core_seq_model_inst.raise(kc, 32'h1234_0000);
      chk("vector one-bit", exp_vec(kc, 1'b0), vector_addr_r);
      chk("vector two-bit", exp_vec(kc, 1'b1), vaddr_two);
    end
    $display("test relocation done");
    {vector_high_select, table_relocate_enable, ext_int_enable} = 3'b001;
    irq_pin_req = 8'h08;
    @(negedge core_clk);
    chk("int redirect", 32'h1, {31'h0, fetch_redirect_r});
    chk("int vector", 32'h0000_0500, vector_addr_r);
    chk("int code", 32'h5, {27'h0, taken_code_r});
    chk("pin rank", 32'h6, {28'h0, int_rank_r});
    // Source 4 at level 2 ranks 5, ahead of pin 3 at rank 6.
    src_req = 8'h10;
    src_level = 24'h00_2000;
    @(negedge core_clk);
    chk("level rank", 32'h5, {28'h0, int_rank_r});
    // A core exception beats the interrupts still pending.
    core_seq_model_inst.raise(5'h02, 32'h5a5a_0000);
    chk("exc over int code", 32'h2, {27'h0, taken_code_r});
    chk("exc over int vector", 32'h0000_0200, vector_addr_r);
    chk("exc over int saved", 32'h5a5a_0000, saved_state_r);
    ext_int_enable = 1'b0;
    @(negedge core_clk);
    chk("masked redirect", 32'h0, {31'h0, fetch_redirect_r});
    chk("pending", 32'h1, {31'h0, int_pending_r});
    {irq_pin_req, src_req} = 16'h0;
    @(negedge core_clk);
    chk("idle rank", 32'hf, {28'h0, int_rank_r});
    chk("idle pending", 32'h0, {31'h0, int_pending_r});
    $display("test interrupts done");
    // Reset in mid-run with pin 0 requesting; outputs return to reset values.
    irq_pin_req = 8'h01;
    ext_int_enable = 1'b1;
    rst_b = 1'b0;
    @(negedge core_clk);
    chk("reset redirect", 32'h0, {31'h0, fetch_redirect_r});
    chk("reset vector", 32'h0, vector_addr_r);
    chk("reset rank", 32'hf, {28'h0, int_rank_r});
    rst_b = 1'b1;
    @(negedge core_clk);
    chk("pin0 redirect", 32'h1, {31'h0, fetch_redirect_r});
    chk("pin0 vector", 32'h0000_0500, vector_addr_r);
    chk("pin0 rank", 32'h0, {28'h0, int_rank_r});
    irq_pin_req = 8'h00;
    @(negedge core_clk);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
